// *** uip_pkg.sv ***
// Constants and types of the per-channel UART interrupt prioritizer
//
// Behaviour
// - Receive-data interrupt on holding data, or FIFO at trigger; drops below trigger.
// - Data-ready status bit sets on a received character, clears when FIFO empty.
// - FIFOs on with mask bits 3:0 clear gives polled mode via line status.
// - Status bit 5 shows transmit holding/FIFO empty; bit 6 adds shifter empty.
// - Bit 1 overrun, bits 2-4 head byte errors, bit 7 any FIFO error.
// - Mask bits 7,6 with unlock and auto CTS/RTS interrupt on rising handshake input or output.
// - Mask bit 5 with unlock interrupts on a received Xoff character.
// - Mask bit 3 raises modem interrupt when any modem delta bit sets.
// - Mask bit 2 raises line-status interrupt at stop bit of errored character.
// - After a status-read clear, re-raise when errored byte reaches FIFO head.
// - Error bits 4:2 follow the head byte only; later errors show in bit 7.
// - Mask bit 1: transmit interrupt on empty; FIFO mode below trigger and empty.
// - Half-duplex direction control delays second transmit interrupt to shifter empty.
// - Source read gives highest pending enabled interrupt; lower ones stay queued.
// - Codes: line status 000110, receive data 000100, receive time-out 001100.
// - Codes: transmit ready 000010, modem status 000000.
// - Codes: flow character 010000, handshake change 100000, none pending 000001.
// - Time-out interrupt after four characters plus twelve bits below trigger.
// - Wake-up indicator on leaving sleep, cleared by global status read.
// - Clears: status read, reads below trigger, receive holding read.
// - Transmit clear by source read or write; flow by source; pins by modem read.
// - Source bits 7:6 read 00 with FIFOs off and 11 with FIFOs on.
// - Source bit 0 reads 0 while pending, 1 when idle, 1 after reset.
package uip_pkg;
   localparam int CNT_W = 9;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int TO_W = 8;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SOURCE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_LINE = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'hc;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] MASK_LOCKED_BITS = 8'he0;
   localparam logic [7:0] MASK_RSVD_BITS = 8'h10;
   localparam logic [5:0] CONFIG_RESET = 6'h00;
   // Mask bit positions
   localparam int MB_RX = 0;
   localparam int MB_TX = 1;
   localparam int MB_LSR = 2;
   localparam int MB_MSR = 3;
   localparam int MB_XOFF = 5;
   localparam int MB_RTS = 6;
   localparam int MB_CTS = 7;
   // Config bit positions
   localparam int CB_FIFO = 0;
   localparam int CB_UNLOCK = 1;
   localparam int CB_ARTS = 2;
   localparam int CB_ACTS = 3;
   localparam int CB_SEL = 4;
   localparam int CB_HDX = 5;
   // Source codes, bits 5:0
   localparam logic [5:0] SRC_LSR = 6'h06;
   localparam logic [5:0] SRC_RECEIVE_READY_EVENT = 6'h04;
   localparam logic [5:0] SRC_RXTO = 6'h0c;
   localparam logic [5:0] SRC_TRANSMIT_READY_EVENT = 6'h02;
   localparam logic [5:0] SRC_MSR = 6'h00;
   localparam logic [5:0] SRC_XCHR = 6'h10;
   localparam logic [5:0] SRC_HSK = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   // Receive time-out length
   localparam logic [3:0] TO_CHARS = 4'h4;
   localparam logic [TO_W-1:0] TO_BITS = 8'h0c;
endpackage

// *** uip_rx_timeout.sv ***
// Receive time-out timer counting bit times
`timescale 1ns/1ps
module uip_rx_timeout
   import uip_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic bit_tick_in,
   input wire logic [3:0] char_bits_in,
   input wire logic arm_in,
   input wire logic restart_in,
   output logic expire_out
);
   logic [TO_W-1:0] count;
   logic [TO_W-1:0] limit;
   logic fired;

   // Four characters plus twelve bits
   assign limit = TO_W'(TO_CHARS) * TO_W'(char_bits_in) + TO_BITS;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count <= '0;
         fired <= 1'b0;
         expire_out <= 1'b0;
      end else begin
         expire_out <= 1'b0;
         if (!arm_in || restart_in) begin
            count <= '0;
            fired <= 1'b0;
         end else if (bit_tick_in && !fired) begin
            // One pulse per idle stretch
            if (count + 1'b1 >= limit) begin
               expire_out <= 1'b1;
               fired <= 1'b1;
            end
            count <= count + 1'b1;
         end
      end
   end
endmodule

// *** uip_interrupt_prioritizer.sv ***
// Interrupt mask, source encoding and line status of one UART channel
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module uip_interrupt_prioritizer
   import uip_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [CNT_W-1:0] rx_count_in,
   input wire logic [CNT_W-1:0] rx_trig_in,
   input wire logic rx_push_in,
   input wire logic rx_push_err_in,
   input wire logic [2:0] rx_head_err_in,
   input wire logic rx_fifo_err_in,
   input wire logic overrun_in,
   input wire logic rhr_read_in,
   input wire logic bit_tick_in,
   input wire logic [3:0] char_bits_in,
   input wire logic [CNT_W-1:0] tx_count_in,
   input wire logic [CNT_W-1:0] tx_trig_in,
   input wire logic tsr_empty_in,
   input wire logic thr_write_in,
   input wire logic [3:0] msr_delta_in,
   input wire logic msr_read_in,
   input wire logic xoff_rx_in,
   input wire logic xon_rx_in,
   input wire logic special_rx_in,
   input wire logic cts_pin_in,
   input wire logic dsr_pin_in,
   input wire logic rts_pin_in,
   input wire logic dtr_pin_in,
   input wire logic wake_in,
   input wire logic global_interrupt_status0_read_in,
   output logic [7:0] line_status_out,
   output logic wake_pending_out,
   output logic irq_out
);
   logic [7:0] interrupt_mask_reg;
   logic [5:0] config_reg;
   logic ack;
   logic req;
   logic [5:0] rd_src;
   logic lsr_pend, to_pend, tx_pend, msr_pend, xchr_pend, hsk_pend;
   logic rx_lvl;
   logic to_fire;
   logic overrun;
   logic [1:0] cts_sync, dsr_sync;
   logic flow_in_q, flow_out_q;
   logic head_err_q, tx_below_q, tx_empty_q;
   logic [5:0] src_code;
   logic [7:0] source_val;
   logic fifo_en;
   logic lsr_rd, src_rd, wr_ok;

   assign fifo_en = config_reg[CB_FIFO];

   // Highest pending enabled source wins
   function automatic logic [5:0] encode(input logic [6:0] p);
      if (p[0]) encode = SRC_LSR;
      else if (p[1]) encode = SRC_RECEIVE_READY_EVENT;
      else if (p[2]) encode = SRC_RXTO;
      else if (p[3]) encode = SRC_TRANSMIT_READY_EVENT;
      else if (p[4]) encode = SRC_MSR;
      else if (p[5]) encode = SRC_XCHR;
      else if (p[6]) encode = SRC_HSK;
      else encode = SRC_NONE;
   endfunction

   // Avalon slave: one wait state per access
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack;
   assign lsr_rd = avs_read_in & ack & (avs_address_in == OFS_LINE);
   assign src_rd = avs_read_in & ack & (avs_address_in == OFS_SOURCE);
   assign wr_ok = avs_write_in & ack & avs_byteenable_in[0];

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // Read data captured in the wait cycle, stable at the accept edge
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avs_readdata_out <= '0;
         rd_src <= SRC_NONE;
      end else if (avs_read_in && !ack) begin
         rd_src <= src_code;
         unique case (avs_address_in)
            OFS_MASK: avs_readdata_out <= {24'h0, interrupt_mask_reg};
            OFS_SOURCE: avs_readdata_out <= {24'h0, source_val};
            OFS_LINE: avs_readdata_out <= {24'h0, line_status_out};
            OFS_CONFIG: avs_readdata_out <= {26'h0, config_reg};
            default: avs_readdata_out <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         interrupt_mask_reg <= MASK_RESET;
      end else if (wr_ok && avs_address_in == OFS_MASK) begin
         // Upper enables are written only while unlocked and are cleared while locked
         interrupt_mask_reg <= config_reg[CB_UNLOCK] ?
            (avs_writedata_in[7:0] & ~MASK_RSVD_BITS) :
            (avs_writedata_in[7:0] & ~MASK_RSVD_BITS & ~MASK_LOCKED_BITS);
      end else if (!config_reg[CB_UNLOCK]) begin
         interrupt_mask_reg <= interrupt_mask_reg & ~MASK_LOCKED_BITS;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         config_reg <= CONFIG_RESET;
      end else if (wr_ok && avs_address_in == OFS_CONFIG) begin
         config_reg <= avs_writedata_in[5:0];
      end
   end

   // CTS and DSR pin inputs cross in through two flops; RTS and DTR are used directly
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cts_sync <= 2'b00;
         dsr_sync <= 2'b00;
      end else begin
         cts_sync <= {cts_sync[0], cts_pin_in};
         dsr_sync <= {dsr_sync[0], dsr_pin_in};
      end
   end

   // Line status; error bits 4:2 track only the head byte
   assign line_status_out[0] = rx_count_in != '0;
   assign line_status_out[1] = overrun;
   assign line_status_out[4:2] = rx_head_err_in;
   assign line_status_out[5] = tx_count_in == '0;
   assign line_status_out[6] = (tx_count_in == '0) & tsr_empty_in;
   assign line_status_out[7] = fifo_en & rx_fifo_err_in;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         overrun <= 1'b0;
      end else if (overrun_in) begin
         overrun <= 1'b1;
      end else if (lsr_rd) begin
         overrun <= 1'b0;
      end
   end

   // Line-status interrupt, set wins over the read clear
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lsr_pend <= 1'b0;
         head_err_q <= 1'b0;
      end else begin
         head_err_q <= |line_status_out[4:1];
         if ((rx_push_in && rx_push_err_in) || overrun_in) begin
            lsr_pend <= 1'b1;
         end else if (|line_status_out[4:1] && !head_err_q) begin
            lsr_pend <= 1'b1;
         end else if (lsr_rd) begin
            lsr_pend <= 1'b0;
         end
      end
   end

   // Receive level source follows the fill directly
   assign rx_lvl = fifo_en ? (rx_count_in >= rx_trig_in)
                           : (rx_count_in != '0);

   uip_rx_timeout u_timeout (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .bit_tick_in(bit_tick_in),
      .char_bits_in(char_bits_in),
      .arm_in(fifo_en && rx_count_in != '0 && !rx_lvl),
      .restart_in(rx_push_in | rhr_read_in),
      .expire_out(to_fire)
   );

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         to_pend <= 1'b0;
      end else if (to_fire) begin
         to_pend <= 1'b1;
      end else if (rhr_read_in) begin
         to_pend <= 1'b0;
      end
   end

   // Transmit: empty edge, and below-trigger edge in FIFO mode, each raise it once
   logic tx_below, tx_empty, tx_set;
   assign tx_below = tx_count_in < tx_trig_in;
   assign tx_empty = config_reg[CB_HDX] ?
      (tx_count_in == '0 && tsr_empty_in) : (tx_count_in == '0);
   assign tx_set = (tx_empty && !tx_empty_q)
      || (fifo_en && tx_below && !tx_below_q);

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_pend <= 1'b0;
         tx_below_q <= 1'b1;
         tx_empty_q <= 1'b1;
      end else begin
         tx_below_q <= tx_below;
         tx_empty_q <= tx_empty;
         if (tx_set) begin
            tx_pend <= 1'b1;
         end else if (thr_write_in || (src_rd && rd_src == SRC_TRANSMIT_READY_EVENT)) begin
            tx_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         msr_pend <= 1'b0;
      end else if (|msr_delta_in) begin
         msr_pend <= 1'b1;
      end else if (msr_read_in) begin
         msr_pend <= 1'b0;
      end
   end

   // Xon and special share the Xoff enable
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         xchr_pend <= 1'b0;
      end else if (xoff_rx_in || xon_rx_in || special_rx_in) begin
         xchr_pend <= 1'b1;
      end else if (src_rd && rd_src == SRC_XCHR) begin
         xchr_pend <= 1'b0;
      end
   end

   // Handshake change; select bit picks the pin pair
   logic flow_in, flow_out, hsk_set;
   assign flow_in = config_reg[CB_SEL] ? dsr_sync[1] : cts_sync[1];
   assign flow_out = config_reg[CB_SEL] ? dtr_pin_in : rts_pin_in;
   assign hsk_set = (flow_in && !flow_in_q && config_reg[CB_ACTS]
                     && interrupt_mask_reg[MB_CTS])
                 || (flow_out && !flow_out_q && config_reg[CB_ARTS]
                     && interrupt_mask_reg[MB_RTS]);

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hsk_pend <= 1'b0;
         flow_in_q <= 1'b0;
         flow_out_q <= 1'b0;
      end else begin
         flow_in_q <= flow_in;
         flow_out_q <= flow_out;
         if (hsk_set) begin
            hsk_pend <= 1'b1;
         end else if (msr_read_in) begin
            hsk_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wake_pending_out <= 1'b0;
      end else if (wake_in) begin
         wake_pending_out <= 1'b1;
      end else if (global_interrupt_status0_read_in) begin
         wake_pending_out <= 1'b0;
      end
   end

   // Masking at the encoder, handshake masked at its set; all low mask bits clear means polling
   logic [6:0] pend;
   assign pend = {hsk_pend,
                  xchr_pend & interrupt_mask_reg[MB_XOFF],
                  msr_pend & interrupt_mask_reg[MB_MSR],
                  tx_pend & interrupt_mask_reg[MB_TX],
                  to_pend & interrupt_mask_reg[MB_RX],
                  rx_lvl & interrupt_mask_reg[MB_RX],
                  lsr_pend & interrupt_mask_reg[MB_LSR]};
   assign src_code = encode(pend);
   assign source_val = {fifo_en, fifo_en, src_code};
   assign irq_out = (src_code != SRC_NONE) | wake_pending_out;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);

   lsr_raise_a: assert property (
      rx_push_in && rx_push_err_in |=> lsr_pend)
      else $error("Errored character did not raise line status");
   lsr_first_a: assert property (
      lsr_pend && interrupt_mask_reg[MB_LSR] |-> src_code == SRC_LSR)
      else $error("Line status not reported first");
   idle_code_a: assert property (
      pend == '0 |-> source_val[0] && source_val[5:1] == '0)
      else $error("Idle source code wrong");
   fifo_bits_a: assert property (
      source_val[7:6] == {2{fifo_en}})
      else $error("FIFO status bits wrong");
   bus_wait_a: assert property (
      req |-> ##[0:1] !avs_waitrequest_out)
      else $error("Waitrequest held too long");
   tx_clear_a: assert property (
      thr_write_in && !tx_set |=> !tx_pend)
      else $error("Transmit write did not clear interrupt");
   to_clear_a: assert property (
      rhr_read_in && !to_fire |=> !to_pend)
      else $error("Holding read did not clear time-out");
   lock_mask_a: assert property (
      !config_reg[CB_UNLOCK] |=> (interrupt_mask_reg & MASK_LOCKED_BITS) == '0)
      else $error("Locked enables set without unlock");
   rx_level_a: assert property (
      fifo_en && interrupt_mask_reg[MB_RX] && rx_count_in >= rx_trig_in
      && !lsr_pend |-> src_code == SRC_RECEIVE_READY_EVENT)
      else $error("Receive trigger not reported");
   wake_a: assert property (
      wake_in |=> wake_pending_out && irq_out)
      else $error("Wake-up not flagged");
   hsk_raise_a: assert property (
      hsk_set |=> hsk_pend)
      else $error("Handshake change not flagged");
   xoff_raise_a: assert property (
      xoff_rx_in |=> xchr_pend)
      else $error("Xoff character not flagged");
   msr_raise_a: assert property (
      |msr_delta_in |=> msr_pend)
      else $error("Modem delta not flagged");
   tx_raise_a: assert property (
      tx_set |=> tx_pend)
      else $error("Transmit ready not flagged");
   overrun_bit_a: assert property (
      overrun_in |=> line_status_out[1])
      else $error("Overrun status not set");

   lsr_seen_c: cover property (lsr_rd && lsr_pend);
   timeout_c: cover property (to_fire ##1 src_code == SRC_RXTO);
   tx_seen_c: cover property (src_rd && rd_src == SRC_TRANSMIT_READY_EVENT);
   hsk_seen_c: cover property (hsk_set ##1 src_code == SRC_HSK);
   polled_c: cover property (fifo_en
      && interrupt_mask_reg[MB_MSR:MB_RX] == '0 && rx_count_in != '0);
endmodule

// *** uip_interrupt_prioritizer_tb.sv ***
// Self-checking register-level testbench of the UART interrupt prioritizer
`timescale 1ns/1ps
module uip_interrupt_prioritizer_tb
   import uip_pkg::*;
;
   localparam int P_PUSH = 0;
   localparam int P_OVR = 1;
   localparam int P_RHR = 2;
   localparam int P_THR = 3;
   localparam int P_MSR = 4;
   localparam int P_XOFF = 5;
   localparam int P_WAKE = 6;
   localparam int P_GLOBAL_INTERRUPT_STATUS0 = 7;
   logic clk_sys_in;
   logic rst_b_in;
   logic [ADDR_W-1:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [DATA_W-1:0] avs_writedata_in;
   logic [3:0] avs_byteenable_in;
   logic [DATA_W-1:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [CNT_W-1:0] rx_count_in;
   logic [CNT_W-1:0] rx_trig_in;
   logic rx_push_err_in;
   logic [2:0] rx_head_err_in;
   logic rx_fifo_err_in;
   logic tick_en;
   logic [3:0] char_bits_in;
   logic [CNT_W-1:0] tx_count_in;
   logic [CNT_W-1:0] tx_trig_in;
   logic tsr_empty_in;
   logic [3:0] msr_delta_in;
   logic cts_pin_in;
   logic rts_pin_in;
   logic [7:0] line_status_out;
   logic wake_pending_out;
   logic irq_out;
   logic [7:0] pls;
   logic [7:0] q;
   int n_errors;
   int cmp_count;
   int cycles;
   // Single-cycle strobes share one vector so one task drives them all
   wire rx_push_in = pls[P_PUSH];
   wire overrun_in = pls[P_OVR];
   wire rhr_read_in = pls[P_RHR];
   wire thr_write_in = pls[P_THR];
   wire msr_read_in = pls[P_MSR];
   wire xoff_rx_in = pls[P_XOFF];
   wire wake_in = pls[P_WAKE];
   wire global_interrupt_status0_read_in = pls[P_GLOBAL_INTERRUPT_STATUS0];
   wire bit_tick_in = tick_en;

   uip_interrupt_prioritizer uut (.clk_sys_in, .rst_b_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
      .avs_readdata_out, .avs_waitrequest_out, .rx_count_in, .rx_trig_in,
      .rx_push_in, .rx_push_err_in, .rx_head_err_in, .rx_fifo_err_in,
      .overrun_in, .rhr_read_in, .bit_tick_in, .char_bits_in, .tx_count_in,
      .tx_trig_in, .tsr_empty_in, .thr_write_in, .msr_delta_in, .msr_read_in,
      .xoff_rx_in, .xon_rx_in(1'b0), .special_rx_in(1'b0), .cts_pin_in,
      .dsr_pin_in(1'b0), .rts_pin_in, .dtr_pin_in(1'b0), .wake_in,
      .global_interrupt_status0_read_in, .line_status_out, .wake_pending_out, .irq_out);

   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   // Hang guard, well above the length of the whole sequence
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         wrap_up();
      end
   end

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until the edge that samples waitrequest low
   task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= ~w;
      avs_writedata_in <= {24'h0, d};
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
      q = avs_readdata_out[7:0];
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask

   task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      bus(a, 1'b0, 8'h00);
      chk(nm, q, e);
   endtask

   task pulse(input int b);
      @(posedge clk_sys_in);
      pls[b] <= 1'b1;
      @(posedge clk_sys_in);
      pls <= 8'h00;
      @(posedge clk_sys_in);
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   task wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      n_errors = 0;
      cmp_count = 0;
      rst_b_in = 1'b0;
      avs_address_in = 4'h0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hf;
      rx_count_in = 9'h000;
      rx_trig_in = 9'h004;
      rx_push_err_in = 1'b0;
      rx_head_err_in = 3'h0;
      rx_fifo_err_in = 1'b0;
      tick_en = 1'b0;
      char_bits_in = 4'ha;
      tx_count_in = 9'h008;
      tx_trig_in = 9'h004;
      tsr_empty_in = 1'b1;
      msr_delta_in = 4'h0;
      cts_pin_in = 1'b0;
      rts_pin_in = 1'b0;
      pls = 8'h00;
      cyc(2);
      rst_b_in <= 1'b1;
      rd(OFS_SOURCE, 8'h01, "source after reset");
      rd(OFS_MASK, MASK_RESET, "mask after reset");
      chk("irq idle", {7'h0, irq_out}, 8'h00);
      wr(OFS_MASK, 8'hff);
      rd(OFS_MASK, 8'h0f, "mask locked");
      wr(OFS_CONFIG, 8'h02);
      wr(OFS_MASK, 8'hff);
      rd(OFS_MASK, 8'hef, "mask unlocked");
      avs_byteenable_in <= 4'he;
      wr(OFS_MASK, 8'h00);
      avs_byteenable_in <= 4'hf;
      rd(OFS_MASK, 8'hef, "mask byte off");
      wr(OFS_CONFIG, 8'h00);
      rd(OFS_MASK, 8'h0f, "mask relock");
      $display("test registers done");
      // Polled mode: FIFO on, low mask bits clear
      wr(OFS_CONFIG, 8'h01);
      wr(OFS_MASK, 8'h00);
      tx_count_in <= 9'h000;
      rx_count_in <= 9'h004;
      pulse(P_PUSH);
      rd(OFS_SOURCE, 8'hc1, "source polled");
      chk("irq polled", {7'h0, irq_out}, 8'h00);
      chk("status polled", line_status_out, 8'h61);
      tsr_empty_in <= 1'b0;
      rx_count_in <= 9'h000;
      cyc(2);
      chk("status shifting", line_status_out, 8'h20);
      tsr_empty_in <= 1'b1;
      $display("test polled done");
      // Several sources pending at once
      tx_count_in <= 9'h008;
      wr(OFS_MASK, 8'h0f);
      pulse(P_THR);
      pulse(P_MSR);
      rd(OFS_SOURCE, 8'hc1, "source cleared");
      pulse(P_OVR);
      rx_count_in <= 9'h004;
      tx_count_in <= 9'h003;
      msr_delta_in <= 4'h1;
      cyc(3);
      chk("irq pending", {7'h0, irq_out}, 8'h01);
      rd(OFS_SOURCE, 8'hc6, "source line");
      rd(OFS_LINE, 8'h03, "status overrun");
      rd(OFS_SOURCE, 8'hc4, "source rx");
      rx_count_in <= 9'h002;
      rd(OFS_SOURCE, 8'hc2, "source tx");
      rd(OFS_SOURCE, 8'hc0, "source modem");
      msr_delta_in <= 4'h0;
      pulse(P_MSR);
      rd(OFS_SOURCE, 8'hc1, "source none");
      tx_count_in <= 9'h000;
      rd(OFS_SOURCE, 8'hc2, "source tx empty");
      pulse(P_THR);
      rd(OFS_SOURCE, 8'hc1, "tx write clear");
      $display("test priority done");
      // Time-out: 4*10+12 = 52 bit ticks below trigger
      pulse(P_RHR);
      tick_en <= 1'b1;
      cyc(30);
      rd(OFS_SOURCE, 8'hc1, "time-out early");
      cyc(30);
      rd(OFS_SOURCE, 8'hcc, "time-out code");
      tick_en <= 1'b0;
      pulse(P_RHR);
      rd(OFS_SOURCE, 8'hc1, "time-out clear");
      $display("test time-out done");
      // Error on a later byte, then the same byte at the head
      rx_push_err_in <= 1'b1;
      rx_fifo_err_in <= 1'b1;
      pulse(P_PUSH);
      rx_push_err_in <= 1'b0;
      chk("status later err", line_status_out & 8'h9e, 8'h80);
      rd(OFS_SOURCE, 8'hc6, "source err");
      bus(OFS_LINE, 1'b0, 8'h00);
      rd(OFS_SOURCE, 8'hc1, "line clear");
      rx_head_err_in <= 3'h1;
      cyc(2);
      chk("status head err", line_status_out & 8'h9e, 8'h84);
      rd(OFS_SOURCE, 8'hc6, "line again");
      bus(OFS_LINE, 1'b0, 8'h00);
      rx_head_err_in <= 3'h0;
      rx_fifo_err_in <= 1'b0;
      $display("test line errors done");
      // Flow character and handshake pins with unlock and auto CTS and RTS
      wr(OFS_CONFIG, 8'h0f);
      wr(OFS_MASK, 8'he0);
      rd(OFS_MASK, 8'he0, "mask flow");
      pulse(P_XOFF);
      rd(OFS_SOURCE, 8'hd0, "source xoff");
      rd(OFS_SOURCE, 8'hc1, "xoff clear");
      cts_pin_in <= 1'b1;
      cyc(5);
      rd(OFS_SOURCE, 8'he0, "source pin");
      pulse(P_MSR);
      rd(OFS_SOURCE, 8'hc1, "pin clear");
      rts_pin_in <= 1'b1;
      cyc(2);
      rd(OFS_SOURCE, 8'he0, "source rts");
      pulse(P_MSR);
      rd(OFS_SOURCE, 8'hc1, "rts clear");
      $display("test flow done");
      // Half-duplex: second tx waits for the shifter
      wr(OFS_CONFIG, 8'h21);
      wr(OFS_MASK, 8'h02);
      tx_count_in <= 9'h008;
      pulse(P_THR);
      tsr_empty_in <= 1'b0;
      tx_count_in <= 9'h000;
      pulse(P_THR);
      rd(OFS_SOURCE, 8'hc1, "hdx waits");
      tsr_empty_in <= 1'b1;
      rd(OFS_SOURCE, 8'hc2, "hdx shifter");
      $display("test half-duplex done");
      // Non-FIFO receive and wake-up
      wr(OFS_CONFIG, 8'h00);
      wr(OFS_MASK, 8'h01);
      rx_count_in <= 9'h001;
      rd(OFS_SOURCE, 8'h04, "non-fifo rx");
      rx_count_in <= 9'h000;
      rd(OFS_SOURCE, 8'h01, "non-fifo empty");
      pulse(P_WAKE);
      chk("wake set", {6'h0, wake_pending_out, irq_out}, 8'h03);
      pulse(P_GLOBAL_INTERRUPT_STATUS0);
      chk("wake clear", {6'h0, wake_pending_out, irq_out}, 8'h00);
      $display("test wake done");
      wrap_up();
   end
endmodule
